// ===== core/fdcfm_pkg.sv
// fdcfm_pkg: constants and carriers for register dump and track format
// assumes one clock shared by host byte path, parameter loads and writer
package fdcfm_pkg;
    localparam logic [7:0]  OP_DUMP      = 8'h0e;
    localparam logic [7:0]  OP_FMT       = 8'h0d;
    localparam logic [7:0]  OP_FMT_MASK  = 8'hbf;
    localparam int          MFM_POS      = 6;
    localparam logic [7:0]  ST0_INVALID  = 8'h80;
    localparam logic [1:0]  ST0_ABNORMAL = 2'h1;
    localparam int          ST1_OR_POS   = 4;
    localparam int          ST1_NW_POS   = 1;
    localparam logic [3:0]  DUMP_LEN     = 4'ha;
    localparam logic [3:0]  FMT_RES_LEN  = 4'h7;
    localparam logic [3:0]  INV_RES_LEN  = 4'h1;
    localparam logic [2:0]  FMT_LAST_IDX = 3'h5;
    localparam logic [7:0]  MAX_CODE     = 8'h06;
    localparam logic [13:0] SECT_BASE    = 14'h0080;
    localparam logic [7:0]  SPEC_RST     = 8'h00;
    localparam logic [7:0]  SPT_EOT_RST  = 8'h00;
    localparam logic        LOCK_RST     = 1'h0;
    // gap, sync, mark, id and crc lengths in bytes, then the byte values written
    localparam logic [13:0] G4A_MFM  = 14'h0050;
    localparam logic [13:0] G4A_FM   = 14'h0028;
    localparam logic [13:0] SYNC_MFM = 14'h000c;
    localparam logic [13:0] SYNC_FM  = 14'h0006;
    localparam logic [13:0] G1_MFM   = 14'h0032;
    localparam logic [13:0] G1_FM    = 14'h001a;
    localparam logic [13:0] G1I_MFM  = 14'h0020;
    localparam logic [13:0] G1I_FM   = 14'h0010;
    localparam logic [13:0] G2_MFM   = 14'h0016;
    localparam logic [13:0] G2_FM    = 14'h000b;
    localparam logic [13:0] G2_PERP  = 14'h0029;
    localparam logic [13:0] MARK_MFM = 14'h0004;
    localparam logic [13:0] MARK_FM  = 14'h0001;
    localparam logic [13:0] LEN_ID   = 14'h0004;
    localparam logic [13:0] LEN_CRC  = 14'h0002;
    localparam logic [13:0] LEN_G4B  = 14'h3fff;
    localparam logic [7:0]  GAP_MFM  = 8'h4e;
    localparam logic [7:0]  GAP_FM   = 8'hff;
    localparam logic [7:0]  SYNC_B   = 8'h00;
    localparam logic [7:0]  PRE_MFM  = 8'ha1;
    localparam logic [7:0]  PRE_IDX  = 8'hc2;
    localparam logic [7:0]  MK_IDX   = 8'hfc;
    localparam logic [7:0]  MK_ID    = 8'hfe;
    localparam logic [7:0]  MK_DATA  = 8'hfb;

    typedef enum logic [1:0] {KIND_DATA, KIND_MARK, KIND_CRC} fdcfm_kind_e;
    typedef enum logic [3:0] {SEG_G4A, SEG_SYNC0, SEG_IAM, SEG_G1, SEG_SYNC1,
        SEG_IDAM, SEG_ID, SEG_CRC1, SEG_G2, SEG_SYNC2, SEG_DAM, SEG_DATA,
        SEG_CRC2, SEG_G3, SEG_G4B} fdcfm_seg_e;
    typedef struct packed {fdcfm_kind_e kind; logic [7:0] value;} fdcfm_wbyte_s;
    typedef struct packed {
        logic implied_seek_enable; logic fifo_dis; logic poll_dis; logic [3:0] queue_threshold;
        logic [7:0] precomp_start_track;
    } fdcfm_cfg_s;
    typedef struct packed {logic [3:0] dc; logic gap; logic wg;} fdcfm_perp_s;
    typedef struct packed {logic [7:0] b0; logic [7:0] b1;} fdcfm_spec_s;
    typedef logic [3:0][7:0] fdcfm_ptr_t;
    localparam fdcfm_cfg_s  CFG_RST  = '{implied_seek_enable: 1'h0, fifo_dis: 1'h1, poll_dis: 1'h0,
                                         queue_threshold: 4'h0, precomp_start_track: 8'h00};
    localparam fdcfm_perp_s PERP_RST = '{dc: 4'h0, gap: 1'h0, wg: 1'h0};
endpackage

// ===== core/fdcfm_core.sv
// fdcfm_core: register dump and format track command handling
// assumes host bytes, parameter loads and disk_req on mclk; pins are async
`timescale 1ns/1ns
module fdcfm_core (
    input  wire logic                  mclk,
    input  wire logic                  nrst,
    input  wire logic                  soft_rst,
    input  wire logic                  cmd_valid,
    input  wire logic [7:0]            cmd_data,
    output logic                       cmd_ready,
    output logic                       res_valid,
    output logic [7:0]                 res_data,
    input  wire logic                  res_ack,
    input  wire logic                  cfg_wr,
    input  wire fdcfm_pkg::fdcfm_cfg_s  cfg_in,
    input  wire logic                  perp_wr,
    input  wire fdcfm_pkg::fdcfm_perp_s perp_in,
    input  wire logic                  lock_wr,
    input  wire logic                  lock_in,
    input  wire logic                  spec_wr,
    input  wire fdcfm_pkg::fdcfm_spec_s spec_in,
    input  wire logic                  iso_format_select,
    input  wire fdcfm_pkg::fdcfm_ptr_t  present_track,
    input  wire logic                  rw_done,
    input  wire logic [7:0]            rw_eot,
    input  wire logic                  index_pin,
    input  wire logic                  wp_pin,
    input  wire logic                  disk_req,
    output logic                       wr_gate,
    output logic                       wr_valid,
    output fdcfm_pkg::fdcfm_wbyte_s     wr_byte,
    output logic                       wr_mfm,
    output logic                       int_pulse
);
    import fdcfm_pkg::*;
    typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_IDX1, ST_TRK, ST_RES} fdcfm_state_e;
    typedef enum logic [1:0] {RM_DUMP, RM_FMT, RM_INV} fdcfm_rmode_e;

    fdcfm_state_e   state_reg;
    fdcfm_rmode_e   rmode_reg;
    fdcfm_seg_e     seg_reg, emit_seg_reg, seg_next;
    fdcfm_cfg_s     cfg_reg;
    fdcfm_perp_s    perp_reg;
    fdcfm_spec_s    spec_reg;
    fdcfm_wbyte_s   wr_byte_reg, cur_byte;
    logic [2:0]     idx_sync_reg;
    logic [1:0]     wp_sync_reg;
    logic           lock_reg, ready_reg, res_valid_reg, gate_reg, wvalid_reg;
    logic           mfm_reg, int_reg, or_reg, nw_reg;
    logic [7:0]     res_data_reg, spt_eot_reg, spt_reg, post_data_gap_reg, fill_reg;
    logic [2:0]     hd_drv_reg, bcnt_reg, idcnt_reg;
    logic [3:0]     res_idx_reg, res_len_reg;
    logic [13:0]    cnt_reg, dlen_reg, len;
    logic [7:0]     sec_left_reg;
    logic [3:0][7:0] id_buf_reg;
    logic [7:0]     mk, pre;
    logic [7:0]     size_code;

    // only the second and third stages feed logic
    wire idx_edge = idx_sync_reg[1] & ~idx_sync_reg[2];
    wire take     = cmd_valid & ready_reg;
    wire op_fmt   = (cmd_data & OP_FMT_MASK) == OP_FMT;
    wire in_exec  = (state_reg == ST_IDX1) || (state_reg == ST_TRK);
    wire last_b   = cnt_reg == len - 14'h1;
    wire perp_fmt = perp_reg.wg | perp_reg.gap;
    wire fmt_end  = (state_reg == ST_TRK) && idx_edge;
    wire emit     = (state_reg == ST_TRK) && !idx_edge && disk_req;
    wire [3:0] res_idx_next = (state_reg == ST_RES) ? res_idx_reg + 4'h1 : 4'h0;

    always_comb begin
        size_code = (cmd_data > MAX_CODE) ? MAX_CODE : cmd_data;
    end

    // segment length and byte, one track layout table
    always_comb begin
        cur_byte = '{kind: KIND_DATA, value: mfm_reg ? GAP_MFM : GAP_FM};
        mk  = MK_ID;
        pre = PRE_MFM;
        len = LEN_G4B;
        case (seg_reg)
            SEG_G4A: len = mfm_reg ? G4A_MFM : G4A_FM;
            SEG_SYNC0, SEG_SYNC1, SEG_SYNC2: begin
                len = mfm_reg ? SYNC_MFM : SYNC_FM;
                cur_byte.value = SYNC_B;
            end
            SEG_IAM, SEG_IDAM, SEG_DAM: begin
                len = mfm_reg ? MARK_MFM : MARK_FM;
                cur_byte.kind = KIND_MARK;
                mk  = (seg_reg == SEG_IAM) ? MK_IDX : (seg_reg == SEG_DAM) ? MK_DATA : MK_ID;
                pre = (seg_reg == SEG_IAM) ? PRE_IDX : PRE_MFM;
            end
            // iso layout has shorter gap one
            SEG_G1: len = iso_format_select ? (mfm_reg ? G1I_MFM : G1I_FM)
                                            : (mfm_reg ? G1_MFM : G1_FM);
            SEG_ID: begin
                len = LEN_ID;
                cur_byte.value = id_buf_reg[cnt_reg[1:0]];
            end
            SEG_CRC1, SEG_CRC2: begin
                len = LEN_CRC;
                cur_byte = '{kind: KIND_CRC, value: 8'h00};
            end
            SEG_G2: len = perp_fmt ? G2_PERP : (mfm_reg ? G2_MFM : G2_FM);
            SEG_DATA: begin
                len = dlen_reg;
                cur_byte.value = fill_reg;
            end
            SEG_G3: len = {6'h00, post_data_gap_reg};
            default: len = LEN_G4B;
        endcase
        if (cur_byte.kind == KIND_MARK)
            cur_byte.value = last_b ? mk : pre;
    end

    always_comb begin
        seg_next = fdcfm_seg_e'(seg_reg + 4'h1);
        if ((seg_reg == SEG_G1 || seg_reg == SEG_G3) && sec_left_reg == 8'h00)
            seg_next = SEG_G4B;
        else if (seg_reg == SEG_G3)
            seg_next = SEG_SYNC1;
    end

    function automatic logic [7:0] rbyte(input logic [3:0] i);
        rbyte = 8'h00;
        if (rmode_reg == RM_INV)
            rbyte = ST0_INVALID;
        else if (rmode_reg == RM_FMT) begin
            if (i == 4'h0)
                rbyte = {(or_reg | nw_reg) ? ST0_ABNORMAL : 2'h0, 3'h0, hd_drv_reg};
            else if (i == 4'h1)
                rbyte = {3'h0, or_reg, 2'h0, nw_reg, 1'h0};
        end else
            case (i)
                4'h0, 4'h1, 4'h2, 4'h3: rbyte = present_track[i[1:0]];
                4'h4: rbyte = spec_reg.b0;
                4'h5: rbyte = spec_reg.b1;
                4'h6: rbyte = spt_eot_reg;
                4'h7: rbyte = {lock_reg, 1'h0, perp_reg.dc, perp_reg.gap, perp_reg.wg};
                4'h8: rbyte = {1'h0, cfg_reg.implied_seek_enable, cfg_reg.fifo_dis, cfg_reg.poll_dis,
                               cfg_reg.queue_threshold};
                4'h9: rbyte = cfg_reg.precomp_start_track;
                default: rbyte = 8'h00;
            endcase
    endfunction

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            idx_sync_reg <= 3'h0;
            wp_sync_reg  <= 2'h0;
        end else begin
            idx_sync_reg <= {idx_sync_reg[1:0], index_pin};
            wp_sync_reg  <= {wp_sync_reg[0], wp_pin};
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            cfg_reg     <= CFG_RST;
            perp_reg    <= PERP_RST;
            spec_reg    <= '{b0: SPEC_RST, b1: SPEC_RST};
            lock_reg    <= LOCK_RST;
            spt_eot_reg <= SPT_EOT_RST;
        end else if (soft_rst) begin
            cfg_reg     <= lock_reg ? '{implied_seek_enable: CFG_RST.implied_seek_enable, fifo_dis: cfg_reg.fifo_dis,
                                        poll_dis: CFG_RST.poll_dis, queue_threshold: cfg_reg.queue_threshold,
                                        precomp_start_track: cfg_reg.precomp_start_track} : CFG_RST;
            perp_reg    <= PERP_RST;
            spec_reg    <= '{b0: SPEC_RST, b1: SPEC_RST};
            spt_eot_reg <= SPT_EOT_RST;
        end else begin
            if (cfg_wr)
                cfg_reg <= cfg_in;
            if (perp_wr)
                perp_reg <= perp_in;
            if (lock_wr)
                lock_reg <= lock_in;
            if (spec_wr)
                spec_reg <= spec_in;
            if (rw_done)
                spt_eot_reg <= rw_eot;
            else if (fmt_end)
                spt_eot_reg <= spt_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst || soft_rst) begin
            state_reg <= ST_IDLE;
            rmode_reg <= RM_INV;
            seg_reg <= SEG_G4A;
            emit_seg_reg <= SEG_G4A;
            ready_reg <= 1'h0;
            res_valid_reg <= 1'h0;
            res_data_reg <= 8'h00;
            res_idx_reg <= 4'h0;
            res_len_reg <= INV_RES_LEN;
            gate_reg <= 1'h0;
            wvalid_reg <= 1'h0;
            wr_byte_reg <= '{kind: KIND_DATA, value: 8'h00};
            mfm_reg <= 1'h0;
            int_reg <= 1'h0;
            or_reg <= 1'h0;
            nw_reg <= 1'h0;
            {spt_reg, post_data_gap_reg, fill_reg, sec_left_reg} <= 32'h0;
            {hd_drv_reg, bcnt_reg, idcnt_reg} <= 9'h0;
            cnt_reg <= 14'h0;
            dlen_reg <= SECT_BASE;
            id_buf_reg <= 32'h0;
        end else begin
            int_reg    <= 1'h0;
            wvalid_reg <= 1'h0;
            // ready is a flop, so it drops one cycle ahead of any hazard
            ready_reg <= ((state_reg == ST_IDLE || state_reg == ST_CMD) &&
                          !(take && (state_reg == ST_IDLE || bcnt_reg == FMT_LAST_IDX))) ||
                         (in_exec && !fmt_end && !(take && idcnt_reg == 3'h3) &&
                          idcnt_reg < 3'h4 && sec_left_reg != 8'h00 &&
                          seg_reg != SEG_IDAM && seg_reg != SEG_ID);
            if (take && in_exec && idcnt_reg < 3'h4) begin
                id_buf_reg[idcnt_reg[1:0]] <= cmd_data;
                idcnt_reg <= idcnt_reg + 3'h1;
            end
            case (state_reg)
                ST_IDLE: if (take) begin
                    seg_reg <= SEG_G4A;
                    {idcnt_reg, or_reg, nw_reg} <= 5'h0;
                    if (op_fmt) begin
                        mfm_reg   <= cmd_data[MFM_POS];
                        bcnt_reg  <= 3'h1;
                        state_reg <= ST_CMD;
                    end else begin
                        rmode_reg <= (cmd_data == OP_DUMP) ? RM_DUMP : RM_INV;
                        res_len_reg <= (cmd_data == OP_DUMP) ? DUMP_LEN : INV_RES_LEN;
                        state_reg <= ST_RES;
                    end
                end
                ST_CMD: if (take) begin
                    bcnt_reg <= bcnt_reg + 3'h1;
                    case (bcnt_reg)
                        3'h1: hd_drv_reg <= cmd_data[2:0];
                        3'h2: dlen_reg <= SECT_BASE << size_code[2:0];
                        3'h3: {spt_reg, sec_left_reg} <= {cmd_data, cmd_data};
                        3'h4: post_data_gap_reg <= cmd_data;
                        default: begin
                            fill_reg    <= cmd_data;
                            rmode_reg   <= RM_FMT;
                            res_len_reg <= FMT_RES_LEN;
                            nw_reg      <= wp_sync_reg[1];
                            int_reg     <= wp_sync_reg[1];
                            state_reg   <= wp_sync_reg[1] ? ST_RES : ST_IDX1;
                        end
                    endcase
                end
                ST_IDX1: if (idx_edge) begin
                    gate_reg  <= 1'h1;
                    cnt_reg   <= 14'h0;
                    seg_reg   <= iso_format_select ? SEG_G1 : SEG_G4A;
                    state_reg <= ST_TRK;
                end
                ST_TRK: if (fmt_end) begin
                    gate_reg  <= 1'h0;
                    int_reg   <= 1'h1;
                    state_reg <= ST_RES;
                end else if (emit) begin
                    wvalid_reg   <= 1'h1;
                    wr_byte_reg  <= cur_byte;
                    emit_seg_reg <= seg_reg;
                    if (seg_reg == SEG_ID && {1'b0, cnt_reg[1:0]} >= idcnt_reg)
                        or_reg <= 1'h1;
                    cnt_reg <= last_b ? 14'h0 : cnt_reg + 14'h1;
                    if (last_b) begin
                        seg_reg <= seg_next;
                        if (seg_reg == SEG_ID) begin
                            idcnt_reg    <= 3'h0;
                            sec_left_reg <= sec_left_reg - 8'h1;
                        end
                    end
                end
                default: ;
            endcase
            if (state_reg == ST_RES && res_valid_reg && res_ack) begin
                res_idx_reg <= res_idx_next;
                res_data_reg <= rbyte(res_idx_next);
                if (res_idx_next == res_len_reg) begin
                    res_valid_reg <= 1'h0;
                    state_reg     <= ST_IDLE;
                end
            end else if (state_reg == ST_RES && !res_valid_reg) begin
                res_idx_reg   <= 4'h0;
                res_data_reg  <= rbyte(4'h0);
                res_valid_reg <= 1'h1;
            end
        end
    end

    assign cmd_ready = ready_reg;
    assign res_valid = res_valid_reg;
    assign res_data  = res_data_reg;
    assign wr_gate   = gate_reg;
    assign wr_valid  = wvalid_reg;
    assign wr_byte   = wr_byte_reg;
    assign wr_mfm    = mfm_reg;
    assign int_pulse = int_reg;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst || soft_rst);

    invalid_opcode_a: assert property (take && state_reg == ST_IDLE && !op_fmt &&
        cmd_data != OP_DUMP |-> ##2 res_valid && res_data == ST0_INVALID && !int_pulse)
        else $error("invalid opcode not answered with 80h");
    dump_byte6_a: assert property (res_valid && rmode_reg == RM_DUMP &&
        res_idx_reg == 4'h6 |-> res_data == $past(spt_eot_reg))
        else $error("dump byte six wrong");
    fmt_ends_a: assert property (fmt_end |=> int_pulse && !wr_gate
        ##1 res_valid && res_data[2:0] == hd_drv_reg)
        else $error("format did not end on second index");
    gate_after_idx_a: assert property ($rose(wr_gate) |-> $past(idx_edge))
        else $error("write gate rose without index");
    fill_pattern_a: assert property (wr_valid && emit_seg_reg == SEG_DATA |->
        wr_byte.value == fill_reg && wr_byte.kind == KIND_DATA)
        else $error("data field not pattern byte");
    id_verbatim_a: assert property (emit && seg_reg == SEG_ID |=>
        wr_byte.value == id_buf_reg[$past(cnt_reg[1:0])])
        else $error("id byte altered");
    data_len_a: assert property (state_reg == ST_TRK && seg_reg == SEG_DATA |->
        cnt_reg < dlen_reg && dlen_reg <= 14'h2000)
        else $error("sector longer than size code");
    // own disable: the default one would swallow every soft reset attempt
    lock_retain_a: assert property (disable iff (!nrst) soft_rst && lock_reg |=>
        cfg_reg.fifo_dis == $past(cfg_reg.fifo_dis) &&
        cfg_reg.queue_threshold == $past(cfg_reg.queue_threshold) && cfg_reg.precomp_start_track == $past(cfg_reg.precomp_start_track))
        else $error("locked fields lost on soft reset");
    fmt_result_len_a: assert property (rmode_reg == RM_FMT && res_valid && res_ack &&
        res_idx_reg == 4'h6 |=> !res_valid)
        else $error("format result not seven bytes");
endmodule

// ===== testbench/fdcfm_disk_model.sv
// fdcfm_disk_model: spinning drive and serializer facing the track writer
// assumes one mclk; tallies written bytes and interrupts for the bench
`timescale 1ns/1ns
module fdcfm_disk_model #(
    parameter int         REV  = 4000,
    parameter logic [7:0] FILL = 8'he5
) (
    input  wire logic                    mclk,
    input  wire logic                    nrst,
    input  wire logic                    wr_gate,
    input  wire logic                    wr_valid,
    input  wire fdcfm_pkg::fdcfm_wbyte_s wr_byte,
    input  wire logic                    int_pulse,
    output logic                         disk_req,
    output logic                         index_pin,
    output logic [15:0]                  n_fill,
    output logic [7:0]                   n_mark,
    output logic [7:0]                   n_int,
    output logic [7:0]                   n_gap2,
    output logic [63:0]                  ids
);
    import fdcfm_pkg::*;
    int rev_cnt;
    int id_left;
    logic in_g2;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            {rev_cnt, id_left, disk_req, index_pin, n_fill, n_mark, n_int, ids} <= '0;
            {in_g2, n_gap2} <= '0;
        end else begin
            rev_cnt <= (rev_cnt == REV - 1) ? 0 : rev_cnt + 1;
            index_pin <= (rev_cnt < 8);
            // slow serializer: one request every four cycles, only while gated
            disk_req <= wr_gate && (rev_cnt % 4 == 0);
            if (wr_valid && wr_byte.kind == KIND_DATA && wr_byte.value == FILL) begin
                n_fill <= n_fill + 16'h1;
            end
            if (wr_valid && wr_byte.kind == KIND_MARK) begin
                n_mark <= n_mark + 8'h1;
            end
            if (wr_valid && wr_byte.kind == KIND_MARK && wr_byte.value == MK_ID) begin
                id_left <= 4;
            end else if (wr_valid && wr_byte.kind == KIND_DATA && id_left > 0) begin
                ids <= {ids[55:0], wr_byte.value};
                id_left <= id_left - 1;
            end
            // gap bytes between id mark and the next mark
            if (wr_valid && wr_byte.kind == KIND_MARK) begin
                in_g2 <= (wr_byte.value == MK_ID);
            end else if (wr_valid && in_g2 && wr_byte.kind == KIND_DATA &&
                         (wr_byte.value == GAP_MFM || wr_byte.value == GAP_FM)) begin
                n_gap2 <= n_gap2 + 8'h1;
            end
            if (int_pulse) begin
                n_int <= n_int + 8'h1;
            end
        end
    end
endmodule

// ===== testbench/fdc_dump_and_format_cmds_test.sv
// fdc_dump_and_format_cmds_test: host sequences for dump, format and bad opcode
// assumes core and disk model share one 125 MHz clock
`timescale 1ns/1ns
module fdc_dump_and_format_cmds_test;
    import fdcfm_pkg::*;
    logic         mclk, nrst, soft_rst, cmd_valid, cmd_ready, res_valid, res_ack;
    logic [7:0]   cmd_data, res_data, rw_eot, n_mark, n_int;
    logic         cfg_wr, perp_wr, lock_wr, lock_in, spec_wr, rw_done, wp_pin;
    logic         iso_format_select, disk_req, index_pin, wr_gate, wr_valid, wr_mfm, int_pulse;
    fdcfm_cfg_s   cfg_in;
    fdcfm_perp_s  perp_in;
    fdcfm_spec_s  spec_in;
    fdcfm_wbyte_s wr_byte;
    fdcfm_ptr_t   present_track;
    logic [15:0]  n_fill;
    logic [7:0]   n_gap2;
    logic [63:0]  ids;
    int           n_errors = 0;
    int           n_compared = 0;
    fdcfm_core dut (
        .mclk              (mclk),
        .nrst              (nrst),
        .soft_rst          (soft_rst),
        .cmd_valid         (cmd_valid),
        .cmd_data          (cmd_data),
        .cmd_ready         (cmd_ready),
        .res_valid         (res_valid),
        .res_data          (res_data),
        .res_ack           (res_ack),
        .cfg_wr            (cfg_wr),
        .cfg_in            (cfg_in),
        .perp_wr           (perp_wr),
        .perp_in           (perp_in),
        .lock_wr           (lock_wr),
        .lock_in           (lock_in),
        .spec_wr           (spec_wr),
        .spec_in           (spec_in),
        .iso_format_select (iso_format_select),
        .present_track     (present_track),
        .rw_done           (rw_done),
        .rw_eot            (rw_eot),
        .index_pin         (index_pin),
        .wp_pin            (wp_pin),
        .disk_req          (disk_req),
        .wr_gate           (wr_gate),
        .wr_valid          (wr_valid),
        .wr_byte           (wr_byte),
        .wr_mfm            (wr_mfm),
        .int_pulse         (int_pulse)
    );
    fdcfm_disk_model disk (
        .mclk      (mclk),
        .nrst      (nrst),
        .wr_gate   (wr_gate),
        .wr_valid  (wr_valid),
        .wr_byte   (wr_byte),
        .int_pulse (int_pulse),
        .disk_req  (disk_req),
        .index_pin (index_pin),
        .n_fill    (n_fill),
        .n_mark    (n_mark),
        .n_int     (n_int),
        .n_gap2    (n_gap2),
        .ids       (ids)
    );
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task step();
        @(posedge mclk);
        #1;
    endtask
    task check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task send(input logic [7:0] b);
        cmd_data = b;
        cmd_valid = 1'b1;
        for (int i = 0; i < 30000 && cmd_ready !== 1'b1; i++) step();
        step();
        cmd_valid = 1'b0;
        step();
    endtask
    task get(input logic [7:0] exp, input logic chk);
        for (int i = 0; i < 30000 && res_valid !== 1'b1; i++) step();
        if (chk) check(res_data, exp);
        res_ack = 1'b1;
        step();
        res_ack = 1'b0;
        step();
    endtask
    task dump(input logic [9:0][7:0] e);
        send(OP_DUMP);
        for (int k = 9; k >= 0; k--) get(e[k], 1'b1);
        check(res_valid, 1'b0);
    endtask
    task fmt(input logic [47:0] c, input int nid, input logic [63:0] id, input logic [7:0] st0,
             input logic [7:0] st1);
        for (int k = 5; k >= 0; k--) send(c[8*k +: 8]);
        for (int k = nid - 1; k >= 0; k--) send(id[8*k +: 8]);
        get(st0, 1'b1);
        get(st1, 1'b1);
        get(8'h00, 1'b1);
        for (int k = 0; k < 4; k++) get(8'h00, 1'b0);
    endtask
    task wrap_up();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        {soft_rst, cmd_valid, res_ack, cfg_wr, perp_wr, lock_wr, spec_wr, rw_done} = '0;
        {wp_pin, iso_format_select, lock_in, cmd_data, rw_eot, spec_in} = '0;
        cfg_in = CFG_RST;
        perp_in = PERP_RST;
        present_track = {8'h44, 8'h33, 8'h22, 8'h11};
        repeat (6) @(posedge mclk);
        #1 nrst = 1'b1;
        step();
        step();
        dump({8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00});
        spec_in = '{b0: 8'ha5, b1: 8'h3c};
        cfg_in = '{implied_seek_enable: 1'h1, fifo_dis: 1'h0, poll_dis: 1'h1, queue_threshold: 4'h9, precomp_start_track: 8'h47};
        perp_in = '{dc: 4'ha, gap: 1'h1, wg: 1'h0};
        lock_in = 1'b1;
        rw_eot = 8'h12;
        {spec_wr, cfg_wr, perp_wr, lock_wr, rw_done} = '1;
        step();
        {spec_wr, cfg_wr, perp_wr, lock_wr, rw_done} = '0;
        step();
        dump({8'h11, 8'h22, 8'h33, 8'h44, 8'ha5, 8'h3c, 8'h12, 8'haa, 8'h59, 8'h47});
        soft_rst = 1'b1;
        step();
        soft_rst = 1'b0;
        step();
        step();
        dump({8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h00, 8'h80, 8'h09, 8'h47});
        // interleaved ids, two 128-byte sectors
        fmt({8'h4d, 8'h05, 8'h00, 8'h02, 8'h10, 8'he5}, 8, 64'h0101030001010100,
            8'h05, 8'h00);
        check(n_fill, 16'd256);
        check(n_mark, 8'd20);
        check(wr_mfm, 1'b1);
        check(n_gap2, 8'd44);
        check(ids, 64'h0101030001010100);
        check(n_int, 8'd1);
        dump({8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h00, 8'h02, 8'h80, 8'h09, 8'h47});
        // perpendicular gap two for the single density track
        iso_format_select = 1'b1;
        perp_in = '{dc: 4'h0, gap: 1'h1, wg: 1'h0};
        perp_wr = 1'b1;
        step();
        perp_wr = 1'b0;
        fmt({8'h0d, 8'h00, 8'h01, 8'h01, 8'h20, 8'he5}, 4, 64'h02000101, 8'h00, 8'h00);
        check(n_fill, 16'd512);
        check(n_mark, 8'd22);
        check(wr_mfm, 1'b0);
        check(n_gap2, 8'd85);
        iso_format_select = 1'b0;
        wp_pin = 1'b1;
        fmt({8'h4d, 8'h02, 8'h02, 8'h09, 8'h2a, 8'he5}, 0, 64'h0, 8'h42, 8'h02);
        check(n_int, 8'd3);
        wp_pin = 1'b0;
        send(8'h00);
        get(ST0_INVALID, 1'b1);
        check(res_valid, 1'b0);
        check(n_int, 8'd3);
        wrap_up();
    end
    // run needs about four disk turns; this allows about twelve
    initial begin
        #400000;
        n_errors++;
        wrap_up();
    end
endmodule
